// ==== common/pfp_params.svh ====
// constants, offsets and field positions of the paired single fp datapath
// How it works
// - negate flips the sign of both single halves of the source and writes the pair.
// - merge-negative takes inverted sign of first source half, other bits of second.
// - every completed paired result gets exponent 0x1003E and a positive sign.
// - a not-a-thing token in any used source replaces the result with that token.
// - negate-absolute clears each half's sign, makes it negative, writes both halves.
// - negative multiply-add: exact product, negated, exact add, one single rounding.
// - each half rounds with the rounding control of the selected status field.
// - addend index zero skips the addition and rounds the negated product.
// - negative multiply is negative multiply-add with register zero as addend.
// - a NaN or infinite default result replaces the arithmetic half result.
// - multiply-add signals invalid, underflow, denormal, overflow, inexact, assist fault/trap.
// - reciprocal with false predicate clears output predicate, leaves destination alone.
// - each reciprocal half approximates one over divisor half or holds IEEE response.
// - infinite, zero or NaN operand halves give the IEEE quotient response.
// - output predicate is the AND of both halves; special or risky halves give 0.
// - inf/finite gives inf, finite/inf or zero/finite gives zero, sign XOR, half fails.
// - divisor limit takes default result; dividend or quotient limit only fails the half.
// - a not-a-thing source of the reciprocal gives the token and clears the predicate.
// - halves are computed apart and joined high above low into the 64-bit significand.
`ifndef PFP_PARAMS_SVH
`define PFP_PARAMS_SVH
`define FP_INTEGER_EXP 17'h1003E
`define FP_SIGN_POSITIVE 1'b0
`define NATVAL_EXP 17'h1FFFE
`define DEFAULT_NAN 32'h7FC00000
`define INF_MAG 31'h7F800000
`define MAX_FINITE 31'h7F7FFFFF
`define FLAG_V 0
`define FLAG_D 1
`define FLAG_Z 2
`define FLAG_O 3
`define FLAG_U 4
`define FLAG_I 5
`define FAULT_MASK 6'h07
`define TRAP_MASK 6'h38
`define REG_CTRL 8'h00
`define REG_FLAGS 8'h04
`define REG_LAST 8'h08
`define CTRL_TRAP_LSB 8
`define CTRL_RESET 14'h0000
`define FLAGS_RESET 24'h000000
`endif

// ==== common/pfp_pkg.sv ====
// types shared by the paired single fp datapath
package pfp_pkg;
   typedef enum logic [2:0] {
      OP_NOP = 3'b000,
      OP_NEG = 3'b001,
      OP_NEGABS = 3'b010,
      OP_MERGE_NS = 3'b011,
      OP_NMA = 3'b100,
      OP_NMPY = 3'b101,
      OP_RCPA = 3'b110
   } op_t;
   typedef enum logic [1:0] {
      RC_NEAREST = 2'b00,
      RC_DOWN = 2'b01,
      RC_UP = 2'b10,
      RC_ZERO = 2'b11
   } rc_t;
   typedef struct packed {
      logic [31:0] val;
      logic pred;
      logic [5:0] flags;
   } half_t;
endpackage : pfp_pkg

// ==== rtl/paired_single_fp_negate_recip.sv ====
// paired single fp negate, negative multiply-add and reciprocal approximation datapath
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`include "pfp_params.svh"
module paired_single_fp_negate_recip
   import pfp_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // decoded operation: srcA is merge/dividend/addend, srcB and srcC the others
   input wire logic opValid,
   input wire op_t opCode,
   input wire logic qualifyingPredicate,
   input wire logic [1:0] statusFieldSelector,
   input wire logic addendIndexZero,
   input wire logic [63:0] srcA,
   input wire logic srcANat,
   input wire logic [63:0] srcB,
   input wire logic srcBNat,
   input wire logic [63:0] srcC,
   input wire logic srcCNat,
   // fp and predicate register file writes
   output logic destWrite,
   output logic [63:0] destSignificand,
   output logic [16:0] destExponent,
   output logic destSign,
   output logic destNat,
   output logic predWrite,
   output logic outputPredicate,
   // exceptions
   output logic faultValid,
   output logic [5:0] faultFlags,
   output logic softwareAssistFault,
   output logic trapValid,
   output logic [5:0] trapFlags,
   output logic softwareAssistTrap,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   function automatic logic isNan(input logic [31:0] x);
      return (x[30:23] == 8'hFF) && (x[22:0] != 23'h0);
   endfunction : isNan
   function automatic logic isInf(input logic [31:0] x);
      return (x[30:23] == 8'hFF) && (x[22:0] == 23'h0);
   endfunction : isInf
   function automatic logic isZero(input logic [31:0] x);
      return x[30:0] == 31'h0;
   endfunction : isZero
   function automatic logic isDen(input logic [31:0] x);
      return (x[30:23] == 8'h00) && (x[22:0] != 23'h0);
   endfunction : isDen
   function automatic logic [23:0] mant(input logic [31:0] x);
      return {|x[30:23], x[22:0]};
   endfunction : mant
   function automatic int effExp(input logic [31:0] x);
      return (x[30:23] == 8'h00) ? 1 : int'(x[30:23]);
   endfunction : effExp

   // one half of negative multiply-add, addend skipped when skip is set
   function automatic half_t nmaHalf(input logic [31:0] ad, input logic [31:0] m1,
         input logic [31:0] m2, input logic skip, input rc_t rc);
      half_t r;
      logic ps, bs, ss, sg, grd, stk, up, tiny;
      logic [47:0] pm, cm;
      logic [74:0] bv, sv, sm, sum, lost;
      logic [23:0] mt;
      logic [24:0] rm;
      int pE, cE, eb, d, lead, eo, s;
      r = '0;
      ps = ~(m1[31] ^ m2[31]);
      r.flags[`FLAG_D] = isDen(m1) | isDen(m2) | (~skip & isDen(ad));
      if (isNan(m1) | isNan(m2) | (~skip & isNan(ad))) begin
         r.flags[`FLAG_V] = (isNan(m1) & ~m1[22]) | (isNan(m2) & ~m2[22])
                          | (~skip & isNan(ad) & ~ad[22]);
         r.val = isNan(m1) ? (m1 | 32'h00400000) : isNan(m2) ? (m2 | 32'h00400000)
               : (ad | 32'h00400000);
      end else if ((isInf(m1) & isZero(m2)) | (isZero(m1) & isInf(m2))
            | ((isInf(m1) | isInf(m2)) & ~skip & isInf(ad) & (ad[31] != ps))) begin
         r.flags[`FLAG_V] = 1'b1;
         r.val = `DEFAULT_NAN;
      end else if (isInf(m1) | isInf(m2)) begin
         r.val = {ps, `INF_MAG};
      end else if (~skip & isInf(ad)) begin
         r.val = ad;
      end else begin
         pm = mant(m1) * mant(m2);
         cm = skip ? 48'h0 : {1'b0, mant(ad), 23'h0};
         pE = (pm == 48'h0) ? -1000 : effExp(m1) + effExp(m2) - 127;
         cE = (cm == 48'h0) ? -1000 : effExp(ad);
         bv = (pE >= cE) ? {pm, 27'h0} : {cm, 27'h0};
         sv = (pE >= cE) ? {cm, 27'h0} : {pm, 27'h0};
         bs = (pE >= cE) ? ps : ad[31];
         ss = (pE >= cE) ? ad[31] : ps;
         eb = (pE >= cE) ? pE : cE;
         d = (pE >= cE) ? pE - cE : cE - pE;
         if (d > 75) begin
            d = 75;
         end
         sm = sv >> d;
         lost = sv << (75 - d);
         sm[0] = sm[0] | (|lost);
         if (bs == ss) begin
            sum = bv + sm;
            sg = bs;
         end else if (bv >= sm) begin
            sum = bv - sm;
            sg = bs;
         end else begin
            sum = sm - bv;
            sg = ss;
         end
         if (sum == 75'h0) begin
            sg = skip ? ps : ((ps == ad[31]) ? ps : (rc == RC_DOWN));
            r.val = {sg, 31'h0};
         end else begin
            lead = 0;
            for (int i = 0; i < 75; i++) begin
               if (sum[i]) begin
                  lead = i;
               end
            end
            eo = lead + eb - 73;
            tiny = eo < 1;
            if (tiny) begin
               eo = 1;
            end
            s = eo + 50 - eb;
            if (s > 75) begin
               s = 75;
            end
            if (s <= 0) begin
               mt = 24'(sum << (-s));
               grd = 1'b0;
               stk = 1'b0;
            end else begin
               mt = 24'(sum >> s);
               grd = sum[s - 1];
               lost = sum << (76 - s);
               stk = |lost;
            end
            case (rc)
               RC_NEAREST: up = grd & (stk | mt[0]);
               RC_DOWN: up = sg & (grd | stk);
               RC_UP: up = ~sg & (grd | stk);
               default: up = 1'b0;
            endcase
            rm = {1'b0, mt} + {24'h0, up};
            if (rm[24]) begin
               rm = rm >> 1;
               eo = eo + 1;
            end
            r.flags[`FLAG_I] = grd | stk;
            r.flags[`FLAG_U] = tiny & (grd | stk);
            if (eo >= 255) begin
               r.flags[`FLAG_O] = 1'b1;
               r.flags[`FLAG_I] = 1'b1;
               up = (rc == RC_NEAREST) | ((rc == RC_UP) & ~sg) | ((rc == RC_DOWN) & sg);
               r.val = {sg, up ? `INF_MAG : `MAX_FINITE};
            end else begin
               r.val = {sg, rm[23] ? 8'(eo) : 8'h00, rm[22:0]};
            end
         end
      end
      return r;
   endfunction : nmaHalf

   // one half of the reciprocal approximation with its predicate outcome
   function automatic half_t rcpHalf(input logic [31:0] num, input logic [31:0] den);
      half_t r;
      logic sg;
      logic [24:0] q;
      int e2, e3, qe;
      r = '0;
      sg = num[31] ^ den[31];
      e2 = int'(num[30:23]);
      e3 = int'(den[30:23]);
      qe = e2 - e3 + 127;
      r.flags[`FLAG_D] = isDen(num) | isDen(den);
      if (isNan(num) | isNan(den)) begin
         r.flags[`FLAG_V] = (isNan(num) & ~num[22]) | (isNan(den) & ~den[22]);
         r.val = isNan(num) ? (num | 32'h00400000) : (den | 32'h00400000);
      end else if ((isInf(num) & isInf(den)) | (isZero(num) & isZero(den))) begin
         r.flags[`FLAG_V] = 1'b1;
         r.val = `DEFAULT_NAN;
      end else if (isZero(den)) begin
         r.flags[`FLAG_Z] = ~isInf(num);
         r.val = {sg, `INF_MAG};
      end else if (isInf(num)) begin
         r.val = {sg, `INF_MAG};
      end else if (isInf(den) | isZero(num)) begin
         r.val = {sg, 31'h0};
      end else if (isDen(den)) begin
         r.val = {sg, `INF_MAG};
      end else if (e3 >= 253) begin
         r.val = {sg, 31'h0};
      end else begin
         q = 25'(48'h800000000000 / {24'h0, mant(den)});
         r.val = q[24] ? {den[31], 8'(254 - e3), 23'h0} : {den[31], 8'(253 - e3), q[22:0]};
         r.pred = ~(isDen(num) | (e2 >= 253) | (qe < 2) | (qe > 253));
      end
      return r;
   endfunction : rcpHalf

   // status fields, trap enables and bus state
   logic [7:0] rcCtrl, next_rcCtrl;
   logic [5:0] trapEn, next_trapEn;
   logic [5:0] sfFlags [4];
   logic [5:0] next_sfFlags [4];
   logic [5:0] pendFlags, next_pendFlags;
   logic [1:0] pendSel, next_pendSel;
   logic trapArm, next_trapArm, trapPend, next_trapPend;
   logic [5:0] trapArmFlags, next_trapArmFlags;
   logic wrPend, next_wrPend;
   logic [7:0] wrAddr, next_wrAddr;
   logic [31:0] next_hrdata;
   // result stage
   logic next_destWrite, next_destSign, next_destNat, next_predWrite, next_outputPredicate;
   logic [63:0] next_destSignificand;
   logic [16:0] next_destExponent;
   logic next_faultValid, next_softwareAssistFault, next_trapValid, next_softwareAssistTrap;
   logic [5:0] next_faultFlags, next_trapFlags;
   logic lastFault, next_lastFault;

   rc_t rc;
   logic skipAdd;
   logic [63:0] mergeSrc;
   logic [31:0] mergeRes [2];
   half_t nmaRes [2];
   half_t rcpRes [2];

   assign rc = rc_t'(rcCtrl[2 * statusFieldSelector +: 2]);
   assign skipAdd = addendIndexZero | (opCode == OP_NMPY);
   assign mergeSrc = (opCode == OP_NEGABS) ? 64'h0 : (opCode == OP_NEG) ? srcB : srcA;

   for (genvar h = 0; h < 2; h++) begin : g_half
      assign mergeRes[h] = {~mergeSrc[32 * h + 31], srcB[32 * h +: 31]};
      assign nmaRes[h] = nmaHalf(srcA[32 * h +: 32], srcB[32 * h +: 32], srcC[32 * h +: 32],
                                 skipAdd, rc);
      assign rcpRes[h] = rcpHalf(srcA[32 * h +: 32], srcB[32 * h +: 32]);
   end

   always_comb begin
      logic known, nat, isRcp;
      logic [5:0] opFlags, hit;
      logic [63:0] res;
      logic pred;
      known = 1'b1;
      nat = 1'b0;
      isRcp = 1'b0;
      opFlags = 6'h00;
      pred = 1'b0;
      res = {mergeRes[1], mergeRes[0]};
      case (opCode)
         OP_NEG, OP_NEGABS: nat = srcBNat;
         OP_MERGE_NS: nat = srcANat | srcBNat;
         OP_NMA, OP_NMPY: begin
            nat = srcBNat | srcCNat | (~skipAdd & srcANat);
            res = {nmaRes[1].val, nmaRes[0].val};
            opFlags = nmaRes[1].flags | nmaRes[0].flags;
         end
         OP_RCPA: begin
            isRcp = 1'b1;
            nat = srcANat | srcBNat;
            res = {rcpRes[1].val, rcpRes[0].val};
            pred = rcpRes[1].pred & rcpRes[0].pred;
            opFlags = rcpRes[1].flags | rcpRes[0].flags;
         end
         default: known = 1'b0;
      endcase
      hit = opFlags & trapEn;
      next_destWrite = 1'b0;
      next_predWrite = 1'b0;
      next_faultValid = 1'b0;
      next_softwareAssistFault = 1'b0;
      next_destSignificand = destSignificand;
      next_destExponent = destExponent;
      next_destSign = destSign;
      next_destNat = destNat;
      next_outputPredicate = outputPredicate;
      next_faultFlags = faultFlags;
      next_lastFault = lastFault;
      next_pendFlags = 6'h00;
      next_pendSel = statusFieldSelector;
      next_trapPend = 1'b0;
      if (opValid && known) begin
         if (!qualifyingPredicate) begin
            next_predWrite = isRcp;
            next_outputPredicate = 1'b0;
         end else if (nat) begin
            next_destWrite = 1'b1;
            next_destSignificand = 64'h0;
            next_destExponent = `NATVAL_EXP;
            next_destSign = `FP_SIGN_POSITIVE;
            next_destNat = 1'b1;
            next_predWrite = isRcp;
            next_outputPredicate = 1'b0;
         end else if (|(hit & `FAULT_MASK)) begin
            next_faultValid = 1'b1;
            next_faultFlags = hit & `FAULT_MASK;
            next_softwareAssistFault = hit[`FLAG_D];
            next_lastFault = 1'b1;
         end else begin
            next_destWrite = 1'b1;
            next_destSignificand = res;
            next_destExponent = `FP_INTEGER_EXP;
            next_destSign = `FP_SIGN_POSITIVE;
            next_destNat = 1'b0;
            next_predWrite = isRcp;
            next_outputPredicate = pred;
            next_lastFault = 1'b0;
            next_pendFlags = opFlags;
            next_trapPend = |(hit & `TRAP_MASK);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         destWrite <= 1'b0;
         destSignificand <= 64'h0;
         destExponent <= 17'h0;
         destSign <= 1'b0;
         destNat <= 1'b0;
         predWrite <= 1'b0;
         outputPredicate <= 1'b0;
         faultValid <= 1'b0;
         faultFlags <= 6'h00;
         softwareAssistFault <= 1'b0;
         lastFault <= 1'b0;
         pendFlags <= 6'h00;
         pendSel <= 2'h0;
         trapPend <= 1'b0;
      end else begin
         destWrite <= next_destWrite;
         destSignificand <= next_destSignificand;
         destExponent <= next_destExponent;
         destSign <= next_destSign;
         destNat <= next_destNat;
         predWrite <= next_predWrite;
         outputPredicate <= next_outputPredicate;
         faultValid <= next_faultValid;
         faultFlags <= next_faultFlags;
         softwareAssistFault <= next_softwareAssistFault;
         lastFault <= next_lastFault;
         pendFlags <= next_pendFlags;
         pendSel <= next_pendSel;
         trapPend <= next_trapPend;
      end
   end

   // flags one edge after the write, trap one edge after the flags
   always_comb begin
      logic addrOk, wr;
      logic [23:0] clr;
      addrOk = hsel && htrans[1] && hready && (hsize == 3'b010);
      wr = wrPend && (wrAddr == `REG_FLAGS);
      clr = wr ? hwdata[23:0] : 24'h0;
      next_wrPend = addrOk && hwrite;
      next_wrAddr = haddr[7:0];
      next_rcCtrl = rcCtrl;
      next_trapEn = trapEn;
      if (wrPend && (wrAddr == `REG_CTRL)) begin
         next_rcCtrl = hwdata[7:0];
         next_trapEn = hwdata[`CTRL_TRAP_LSB +: 6];
      end
      for (int f = 0; f < 4; f++) begin
         next_sfFlags[f] = (sfFlags[f] & ~clr[6 * f +: 6])
                         | ((pendSel == 2'(f)) ? pendFlags : 6'h00);
      end
      next_trapArm = trapPend;
      next_trapArmFlags = pendFlags & trapEn & `TRAP_MASK;
      next_trapValid = trapArm;
      next_trapFlags = trapArm ? trapArmFlags : trapFlags;
      next_softwareAssistTrap = trapArm & trapArmFlags[`FLAG_U];
      next_hrdata = hrdata;
      if (addrOk && !hwrite) begin
         case (haddr[7:0])
            `REG_CTRL: next_hrdata = {18'h0, trapEn, rcCtrl};
            `REG_FLAGS: next_hrdata = {8'h0, sfFlags[3], sfFlags[2], sfFlags[1], sfFlags[0]};
            `REG_LAST: next_hrdata = {29'h0, trapValid, lastFault, outputPredicate};
            default: next_hrdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         {trapEn, rcCtrl} <= `CTRL_RESET;
         {sfFlags[3], sfFlags[2], sfFlags[1], sfFlags[0]} <= `FLAGS_RESET;
         wrPend <= 1'b0;
         wrAddr <= 8'h00;
         trapArm <= 1'b0;
         trapArmFlags <= 6'h00;
         trapValid <= 1'b0;
         trapFlags <= 6'h00;
         softwareAssistTrap <= 1'b0;
         hrdata <= 32'h0;
      end else begin
         rcCtrl <= next_rcCtrl;
         trapEn <= next_trapEn;
         sfFlags <= next_sfFlags;
         wrPend <= next_wrPend;
         wrAddr <= next_wrAddr;
         trapArm <= next_trapArm;
         trapArmFlags <= next_trapArmFlags;
         trapValid <= next_trapValid;
         trapFlags <= next_trapFlags;
         softwareAssistTrap <= next_softwareAssistTrap;
         hrdata <= next_hrdata;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule : paired_single_fp_negate_recip

// ==== tb/pfp_monitor.sv ====
// port checker for the paired single fp datapath
`include "pfp_params.svh"
module pfp_monitor
   import pfp_pkg::*;
(
   // clock, reset and operation
   input wire logic core_clk,
   input wire logic srst,
   input wire logic opValid,
   input wire op_t opCode,
   input wire logic qualifyingPredicate,
   input wire logic [63:0] srcA,
   input wire logic [63:0] srcB,
   input wire logic srcANat,
   input wire logic srcBNat,
   input wire logic srcCNat,
   // results
   input wire logic destWrite,
   input wire logic [63:0] destSignificand,
   input wire logic [16:0] destExponent,
   input wire logic destSign,
   input wire logic destNat,
   input wire logic predWrite,
   input wire logic outputPredicate,
   input wire logic faultValid,
   input wire logic trapValid
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [63:0] SIGNS = 64'h80000000_80000000;
   logic [63:0] lastA;
   logic [63:0] lastB;
   wire logic go = opValid && qualifyingPredicate;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (srst);
   // sources of the op taken one edge ago
   always_ff @(posedge core_clk) begin
      lastA <= srcA;
      lastB <= srcB;
   end
   neg_pair_a: assert property (
      go && opCode == OP_NEG && !srcBNat |=> destWrite && !destSign
      && destExponent == `FP_INTEGER_EXP && destSignificand == (lastB ^ SIGNS))
      else $error("negate result wrong");
   merge_ns_a: assert property (
      go && opCode == OP_MERGE_NS && !srcANat && !srcBNat |=> destWrite
      && destSignificand == {~lastA[63], lastB[62:32], ~lastA[31], lastB[30:0]})
      else $error("merge result wrong");
   nat_dest_a: assert property (
      go && opCode inside {OP_NMA, OP_NMPY} && (srcBNat || srcCNat)
      |=> destWrite && destNat && destExponent == `NATVAL_EXP)
      else $error("token not written");
   qp_off_a: assert property (
      opValid && !qualifyingPredicate
      && opCode inside {OP_NEG, OP_NEGABS, OP_MERGE_NS, OP_NMA, OP_NMPY}
      |=> !destWrite && !predWrite && !faultValid)
      else $error("write with false predicate");
   rcp_off_a: assert property (
      opValid && !qualifyingPredicate && opCode == OP_RCPA
      |=> predWrite && !outputPredicate && !destWrite)
      else $error("reciprocal off wrong");
   rcp_nat_a: assert property (
      go && opCode == OP_RCPA && (srcANat || srcBNat)
      |=> destWrite && destNat && predWrite && !outputPredicate)
      else $error("reciprocal token wrong");
   fault_stop_a: assert property (
      faultValid |-> !destWrite && !predWrite)
      else $error("write during fault");
   trap_order_a: assert property (
      trapValid |-> $past(destWrite, 2))
      else $error("trap without result");
endmodule : pfp_monitor

// ==== tb/fp_regfile_model.sv ====
// register file side: keeps the last fp and predicate values written
module fp_regfile_model (
   // clock and write ports
   input wire logic core_clk,
   input wire logic destWrite,
   input wire logic [63:0] destSignificand,
   input wire logic predWrite,
   input wire logic outputPredicate,
   // register contents
   output logic [63:0] frSig = 64'h0,
   output logic prVal = 1'b0,
   output int nWrites = 0
);
   timeunit 1ns;
   timeprecision 100ps;
   always @(posedge core_clk) begin
      if (destWrite) begin
         frSig <= destSignificand;
         nWrites <= nWrites + 1;
      end
      if (predWrite) prVal <= outputPredicate;
   end
endmodule : fp_regfile_model

// ==== tb/tb.sv ====
// self-checking bench for the paired single fp datapath
`include "pfp_params.svh"
module tb
   import pfp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [63:0] ONE2 = 64'h3F800000_3F800000, TWO2 = 64'h40000000_40000000;
   localparam logic [63:0] MB = 64'h40000000_3FC00000, MC = 64'h40400000_40000000;
   localparam logic [63:0] AD = 64'h3F800000_3F000000, EPS = 64'h3F800001_3F800001;
   logic core_clk = 1'b0, srst = 1'b1, opValid = 1'b0, qualifyingPredicate = 1'b0;
   logic addendIndexZero = 1'b0, srcANat = 1'b0, srcBNat = 1'b0, srcCNat = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, destWrite, destSign, destNat, predWrite;
   logic outputPredicate, faultValid, trapValid, softwareAssistFault, softwareAssistTrap;
   logic hreadyout, hresp, prVal;
   op_t opCode = OP_NOP;
   logic [1:0] statusFieldSelector = 2'h0, htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [63:0] srcA = 64'h0, srcB = 64'h0, srcC = 64'h0, destSignificand, frSig, a, b, s, e;
   logic [16:0] destExponent;
   logic [5:0] faultFlags, trapFlags;
   wire logic hready = hreadyout;
   wire logic [83:0] dst = {destWrite, destNat, destSign, destExponent, destSignificand};
   int fails = 0, nChecks = 0, nWrites, w;
   op_t natOp[6] = '{OP_NEG, OP_NEGABS, OP_MERGE_NS, OP_NMA, OP_NMPY, OP_RCPA};
   logic [2:0] natSel[6] = '{3'h2, 3'h2, 3'h4, 3'h1, 3'h2, 3'h4};
   paired_single_fp_negate_recip DUT (.core_clk, .srst, .opValid, .opCode,
      .qualifyingPredicate, .statusFieldSelector, .addendIndexZero, .srcA, .srcANat,
      .srcB, .srcBNat, .srcC, .srcCNat, .destWrite, .destSignificand, .destExponent,
      .destSign, .destNat, .predWrite, .outputPredicate, .faultValid, .faultFlags,
      .softwareAssistFault, .trapValid, .trapFlags, .softwareAssistTrap, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp);
   fp_regfile_model RF (.core_clk, .destWrite, .destSignificand, .predWrite,
      .outputPredicate, .frSig, .prVal, .nWrites);
   always #10 core_clk = ~core_clk;
   task automatic chk(input string what, input logic [96:0] exp, input logic [96:0] got);
      nChecks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic run(input op_t op, input logic qp, input logic [1:0] sf, input logic z,
         input logic [2:0] n, input logic [63:0] a, input logic [63:0] b,
         input logic [63:0] c);
      @(posedge core_clk);
      opValid <= 1'b1;
      opCode <= op;
      {qualifyingPredicate, statusFieldSelector, addendIndexZero} <= {qp, sf, z};
      {srcANat, srcBNat, srcCNat, srcA, srcB, srcC} <= {n, a, b, c};
      @(posedge core_clk);
      opValid <= 1'b0;
      #1;
   endtask : run
   task automatic res(input op_t op, input logic [1:0] sf, input logic z,
         input logic [63:0] a, input logic [63:0] b, input logic [63:0] c,
         input logic [63:0] e, input logic p);
      run(op, 1'b1, sf, z, 3'h0, a, b, c);
      chk("result", {3'h4, `FP_INTEGER_EXP, e}, dst);
      if (op == OP_RCPA) chk("pred", {1'b1, p}, {predWrite, outputPredicate});
   endtask : res
   task automatic rcp(input logic [63:0] a, input logic [63:0] b, input logic [63:0] e,
         input logic p);
      res(OP_RCPA, 2'h0, 1'b0, a, b, 64'h0, e, p);
   endtask : rcp
   // one word transfer, waits on hready
   task automatic ahb(input logic wr, input logic [31:0] adr, input logic [31:0] wd);
      @(posedge core_clk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, adr};
      do @(posedge core_clk); while (hready !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
      do @(posedge core_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", nChecks, fails);
      if (fails == 0 && nChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   initial begin
      repeat (5000) @(posedge core_clk);
      fails++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'h8D760FA4));
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      for (int i = 0; i < 24; i++) begin
         a = {$urandom, $urandom};
         b = {$urandom, $urandom};
         s = (i % 3 == 0) ? b : (i % 3 == 1) ? 64'h0 : a;
         e = {~s[63], b[62:32], ~s[31], b[30:0]};
         res(op_t'(i % 3 + 1), 2'h0, 1'b0, a, b, 64'h0, e, 1'b0);
      end
      $display("test sign forms done");
      res(OP_NMA, 2'h0, 1'b0, AD, MB, MC, 64'hC0A00000_C0200000, 1'b0);
      res(OP_NMA, 2'h0, 1'b1, AD, MB, MC, 64'hC0C00000_C0400000, 1'b0);
      res(OP_NMPY, 2'h0, 1'b0, AD, MB, MC, 64'hC0C00000_C0400000, 1'b0);
      ahb(1'b1, `REG_CTRL, 32'h2004);
      res(OP_NMA, 2'h1, 1'b1, AD, EPS, EPS, 64'hBF800003_BF800003, 1'b0);
      repeat (2) @(posedge core_clk);
      #1;
      chk("trap", 8'hC0, {trapValid, trapFlags, softwareAssistTrap});
      ahb(1'b0, `REG_FLAGS, 32'h0);
      chk("flags", 32'h800, rd);
      res(OP_NMA, 2'h0, 1'b1, AD, EPS, EPS, 64'hBF800002_BF800002, 1'b0);
      $display("test multiply-add done");
      rcp(ONE2, 64'h40000000C0800000, 64'h3F000000BE800000, 1'b1);
      rcp(64'h7F8000003F800000, 64'h400000007F800000, 64'h7F80000000000000, 1'b0);
      rcp(64'h800000003F800000, TWO2, 64'h800000003F000000, 1'b0);
      rcp(64'h7FC000013F800000, TWO2, 64'h7FC000013F000000, 1'b0);
      rcp(64'h3F8000007E800000, 64'h0000000140000000, 64'h7F8000003F000000, 1'b0);
      rcp(ONE2, TWO2, 64'h3F0000003F000000, 1'b1);
      $display("test reciprocal done");
      foreach (natOp[i]) begin
         run(natOp[i], 1'b1, 2'h0, 1'b0, natSel[i], ONE2, TWO2, TWO2);
         chk("token", {3'h6, `NATVAL_EXP, 64'h0}, dst);
      end
      @(posedge core_clk);
      #1;
      chk("token pred", 1'b0, prVal);
      rcp(ONE2, TWO2, 64'h3F0000003F000000, 1'b1);
      @(posedge core_clk);
      #1 w = nWrites;
      foreach (natOp[i]) run(natOp[i], 1'b0, 2'h0, 1'b0, 3'h0, a, b, TWO2);
      @(posedge core_clk);
      #1;
      chk("hold", {w, 64'h3F0000003F000000, 1'b0}, {nWrites, frSig, prVal});
      $display("test predicate done");
      ahb(1'b1, `REG_CTRL, 32'h2404);
      ahb(1'b1, `REG_FLAGS, 32'hFFFFFF);
      w = nWrites;
      run(OP_RCPA, 1'b1, 2'h0, 1'b0, 3'h0, ONE2, 64'h4000000000000000, TWO2);
      chk("fault", 8'h88, {faultValid, faultFlags, softwareAssistFault});
      ahb(1'b0, `REG_FLAGS, 32'h0);
      chk("fault hold", {w, 32'h0}, {nWrites, rd});
      ahb(1'b0, `REG_CTRL, 32'h0);
      chk("ctrl", 32'h2404, rd);
      ahb(1'b0, 32'h10, 32'h0);
      chk("unmapped", 33'h0, {hresp, rd});
      $display("test fault and bus done");
      end_of_test();
   end
endmodule : tb
bind paired_single_fp_negate_recip pfp_monitor MON (.core_clk, .srst, .opValid, .opCode,
   .qualifyingPredicate, .srcA, .srcB, .srcANat, .srcBNat, .srcCNat, .destWrite,
   .destSignificand, .destExponent, .destSign, .destNat, .predWrite, .outputPredicate,
   .faultValid, .trapValid);
